// ===== shared/core_io_pkg.sv
// Constants shared by the core I/O register bank and its counter16 unit
package core_io_pkg;
    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_ALU_COND = 6'h00;
    localparam logic [5:0] IDX_STACK_INDEX = 6'h02;
    localparam logic [5:0] IDX_CLOCK_SELECT = 6'h03;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h04;
    localparam logic [5:0] IDX_IRQ_PENDING = 6'h05;
    localparam logic [5:0] IDX_COUNTER16_CFG = 6'h06;
    localparam logic [5:0] IDX_BANDGAP_PD = 6'h0A;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ALU_Z_BIT = 0;
    localparam int ALU_C_BIT = 1;
    localparam int ALU_AC_BIT = 2;
    localparam int ALU_OV_BIT = 3;
    localparam logic [3:0] ALU_RSVD_READ = 4'hF;
    localparam int CS_PIN5_BIT = 0;
    localparam int CS_WDT_BIT = 1;
    localparam int CS_SLOW_BIT = 2;
    localparam int CS_TYPE_BIT = 3;
    localparam int CS_FAST_BIT = 4;
    localparam int CS_SEL_LSB = 5;
    localparam int IRQ_PIN0_BIT = 0;
    localparam int IRQ_CNT16_BIT = 2;
    localparam int IRQ_CMP_BIT = 4;
    localparam int IRQ_AUX_BIT = 6;
    localparam logic [7:0] IRQ_IMPL_MASK = 8'h55;
    localparam int C16_SEL_LSB = 0;
    localparam int C16_DIV_LSB = 3;
    localparam int C16_SRC_LSB = 5;
    localparam int BG_PD_BIT = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CLOCK_SELECT_RST = 8'hF6;
    localparam logic [7:0] STACK_INDEX_RST = 8'h00;
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;
    localparam logic [7:0] COUNTER16_CFG_RST = 8'h00;
    localparam logic [3:0] ALU_COND_RST = 4'h0;

    // ------------------------------------------------------------------
    // Counter16 clock sources
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        C16_OFF = 3'h0,
        C16_SYSCLK = 3'h1,
        C16_PIN4_FALL = 3'h3,
        C16_FAST_OSC = 3'h4,
        C16_SLOW_OSC = 3'h6,
        C16_PIN0_FALL = 3'h7
    } c16_src_t;

    // Event bit of counter16 is bit 8 plus the select code
    localparam int C16_EVT_BASE = 8;

    // Last prescaler count for divide by 1, 4, 16, 64
    function automatic logic [5:0] presc_last(input logic [1:0] code);
        presc_last = 6'(({6'h00, 1'b1} << {code, 1'b0}) - 7'h01);
    endfunction
endpackage

// ===== rtl/counter16_unit.sv
// Counter16: source select, prescaler and bit-change event
`timescale 1ns/1ps
module counter16_unit #(
    parameter int WIDTH = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [2:0] i_src,
    input wire logic [1:0] i_div,
    input wire logic [2:0] i_bit_sel,
    input wire logic i_fast_tick,
    input wire logic i_slow_tick,
    input wire logic i_pin4_fall,
    input wire logic i_pin0_fall,
    output logic [WIDTH-1:0] o_count,
    output logic o_event
);
    logic src_tick;
    logic [5:0] presc_q;
    logic presc_done;
    logic sel_bit;
    logic sel_prev_q;

    // ------------------------------------------------------------------
    // Source and prescaler
    // ------------------------------------------------------------------
    // Source select by code
    always_comb begin
        case (i_src)
            core_io_pkg::C16_SYSCLK: src_tick = 1'b1;
            core_io_pkg::C16_PIN4_FALL: src_tick = i_pin4_fall;
            core_io_pkg::C16_FAST_OSC: src_tick = i_fast_tick;
            core_io_pkg::C16_SLOW_OSC: src_tick = i_slow_tick;
            core_io_pkg::C16_PIN0_FALL: src_tick = i_pin0_fall;
            default: src_tick = 1'b0; // Off and reserved codes
        endcase
    end

    assign presc_done = (presc_q >= core_io_pkg::presc_last(i_div));

    // Prescaler divides the selected source
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            presc_q <= 6'h00;
        end else if (src_tick) begin
            presc_q <= presc_done ? 6'h00 : presc_q + 6'h01;
        end
    end

    // Counter advances once per prescaler period
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_count <= '0;
        end else if (src_tick && presc_done) begin
            o_count <= o_count + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Bit-change event
    // ------------------------------------------------------------------
    assign sel_bit = o_count[core_io_pkg::C16_EVT_BASE + int'(i_bit_sel)];

    // Event on any change of the selected bit
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_prev_q <= 1'b0;
            o_event <= 1'b0;
        end else begin
            sel_prev_q <= sel_bit;
            o_event <= (sel_bit != sel_prev_q);
        end
    end

    chk_presc_wrap: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        src_tick && presc_done |=> presc_q == 6'h00)
        else $error("prescaler did not wrap");
endmodule

// ===== rtl/core_io_control_registers.sv
// Core I/O register bank: flags, stack, clock, interrupts, counter16
`timescale 1ns/1ps
module core_io_control_registers #(
    parameter int COUNTER_WIDTH = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic [3:0] i_alu_upd,
    input wire logic [3:0] i_alu_flags,
    input wire logic i_aux_timer_evt,
    input wire logic i_comparator_evt,
    input wire logic i_port_pin0,
    input wire logic i_port_pin4,
    input wire logic i_fast_rc_osc,
    input wire logic i_slow_rc_osc,
    output logic [3:0] o_alu_flags,
    output logic [7:0] o_stack_index,
    output logic o_fast_osc_en,
    output logic o_slow_osc_en,
    output logic o_wdt_en,
    output logic o_ext_reset_sel,
    output logic o_sysclk_slow,
    output logic [2:0] o_sysclk_div_log2,
    output logic o_sysclk_reserved,
    output logic [7:0] o_irq_mask,
    output logic [7:0] o_irq_pending,
    output logic o_bandgap_pd,
    output logic [COUNTER_WIDTH-1:0] o_counter16
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    logic [3:0] alu_q;
    logic [3:0] alu_d;
    logic [7:0] stack_q;
    logic [7:0] clk_sel_q;
    logic [7:0] mask_q;
    logic [7:0] pend_q;
    logic [7:0] pend_d;
    logic [7:0] c16_cfg_q;
    logic bg_pd_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [5:0] idx;
    logic req;
    logic wr_take;
    logic [7:0] wdat;
    logic [7:0] rd_byte;
    logic [7:0] evt;
    logic [4:0] clk_dec;
    logic c16_evt;
    logic [COUNTER_WIDTH-1:0] c16_count;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] sync3_q;
    logic pin0_fall;
    logic pin4_fall;
    logic pin0_edge;
    logic fast_tick;
    logic slow_tick;

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    assign idx = i_wb_adr[7:2];
    assign req = i_wb_cyc && i_wb_stb;
    assign wr_take = req && ack_q && i_wb_we && i_wb_sel[0];
    assign wdat = i_wb_dat[7:0];

    // Ack one cycle after request, dropped the cycle after
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    // Read mux; unmapped and write-only return zero
    always_comb begin
        case (idx)
            core_io_pkg::IDX_ALU_COND:
                rd_byte = {core_io_pkg::ALU_RSVD_READ, alu_q};
            core_io_pkg::IDX_STACK_INDEX: rd_byte = stack_q;
            core_io_pkg::IDX_CLOCK_SELECT: rd_byte = clk_sel_q;
            core_io_pkg::IDX_IRQ_MASK: rd_byte = mask_q;
            core_io_pkg::IDX_IRQ_PENDING: rd_byte = pend_q;
            core_io_pkg::IDX_COUNTER16_CFG: rd_byte = c16_cfg_q;
            default: rd_byte = 8'h00; // Bandgap reg reads zero
        endcase
    end

    // Read data captured with the ack
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdat_q <= 32'h0000_0000;
        end else if (req && !ack_q) begin
            rdat_q <= {24'h00_0000, rd_byte};
        end else begin
            rdat_q <= 32'h0000_0000;
        end
    end

    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;
    // ------------------------------------------------------------------
    // Arithmetic status flags
    // ------------------------------------------------------------------
    // ALU update per flag wins over a software write
    always_comb begin
        alu_d = alu_q;
        if (wr_take && idx == core_io_pkg::IDX_ALU_COND) begin
            alu_d = wdat[3:0];
        end
        for (int i = 0; i < 4; i++) begin
            if (i_alu_upd[i]) begin
                alu_d[i] = i_alu_flags[i];
            end
        end
    end

    // Flag storage
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            alu_q <= core_io_pkg::ALU_COND_RST;
        end else begin
            alu_q <= alu_d;
        end
    end

    assign o_alu_flags = alu_q;
    // ------------------------------------------------------------------
    // Stack index, clock select, mask, counter16 config, bandgap
    // ------------------------------------------------------------------
    // Register storage; mask keeps implemented bits only, bandgap bit is write-only
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stack_q <= core_io_pkg::STACK_INDEX_RST;
            clk_sel_q <= core_io_pkg::CLOCK_SELECT_RST;
            mask_q <= core_io_pkg::IRQ_MASK_RST;
            c16_cfg_q <= core_io_pkg::COUNTER16_CFG_RST;
            bg_pd_q <= 1'b0;
        end else if (wr_take) begin
            case (idx)
                core_io_pkg::IDX_STACK_INDEX: stack_q <= wdat;
                core_io_pkg::IDX_CLOCK_SELECT: clk_sel_q <= wdat;
                core_io_pkg::IDX_IRQ_MASK:
                    mask_q <= wdat & core_io_pkg::IRQ_IMPL_MASK;
                core_io_pkg::IDX_COUNTER16_CFG: c16_cfg_q <= wdat;
                core_io_pkg::IDX_BANDGAP_PD:
                    bg_pd_q <= wdat[core_io_pkg::BG_PD_BIT];
                default: ;
            endcase
        end
    end

    assign o_stack_index = stack_q;
    assign o_irq_mask = mask_q;
    // ------------------------------------------------------------------
    // System clock decode
    // ------------------------------------------------------------------
    // Returns {reserved, slow, log2 divider}
    function automatic logic [4:0] sysclk_decode(input logic type1,
                                                 input logic [2:0] code);
        logic [4:0] r;
        r = {1'b1, 1'b0, 3'h0};
        if (!type1) begin
            case (code)
                3'h0: r = {1'b0, 1'b0, 3'h2};
                3'h1: r = {1'b0, 1'b0, 3'h1};
                3'h6: r = {1'b0, 1'b1, 3'h2};
                3'h7: r = {1'b0, 1'b1, 3'h0};
                default: r = {1'b1, 1'b0, 3'h0};
            endcase
        end else begin
            case (code)
                3'h0: r = {1'b0, 1'b0, 3'h4};
                3'h1: r = {1'b0, 1'b0, 3'h3};
                3'h2: r = {1'b0, 1'b1, 3'h4};
                3'h3: r = {1'b0, 1'b0, 3'h5};
                3'h4: r = {1'b0, 1'b0, 3'h6};
                default: r = {1'b1, 1'b0, 3'h0};
            endcase
        end
        return r;
    endfunction

    assign clk_dec = sysclk_decode(clk_sel_q[core_io_pkg::CS_TYPE_BIT],
        clk_sel_q[core_io_pkg::CS_SEL_LSB +: 3]);
    // Registered control outputs
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fast_osc_en <= 1'b1;
            o_slow_osc_en <= 1'b1;
            o_wdt_en <= 1'b1;
            o_ext_reset_sel <= 1'b0;
            o_sysclk_slow <= 1'b1;
            o_sysclk_div_log2 <= 3'h0;
            o_sysclk_reserved <= 1'b0;
            o_bandgap_pd <= 1'b0;
        end else begin
            o_fast_osc_en <= clk_sel_q[core_io_pkg::CS_FAST_BIT]
                && !bg_pd_q;
            o_slow_osc_en <= clk_sel_q[core_io_pkg::CS_SLOW_BIT];
            o_wdt_en <= clk_sel_q[core_io_pkg::CS_WDT_BIT]
                && clk_sel_q[core_io_pkg::CS_SLOW_BIT];
            o_ext_reset_sel <= clk_sel_q[core_io_pkg::CS_PIN5_BIT];
            o_sysclk_slow <= clk_dec[3];
            o_sysclk_div_log2 <= clk_dec[2:0];
            o_sysclk_reserved <= clk_dec[4];
            o_bandgap_pd <= bg_pd_q;
        end
    end

    // ------------------------------------------------------------------
    // Pin and oscillator synchronisers
    // ------------------------------------------------------------------
    // Two-flop sync, third stage for edge detection
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
        end else begin
            sync1_q <= {i_slow_rc_osc, i_fast_rc_osc, i_port_pin4,
                        i_port_pin0};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign pin0_fall = sync3_q[0] && !sync2_q[0];
    assign pin0_edge = sync3_q[0] != sync2_q[0];
    assign pin4_fall = sync3_q[1] && !sync2_q[1];
    assign fast_tick = sync2_q[2] && !sync3_q[2] && o_fast_osc_en;
    assign slow_tick = sync2_q[3] && !sync3_q[3] && o_slow_osc_en;

    // ------------------------------------------------------------------
    // Counter16
    // ------------------------------------------------------------------
    counter16_unit #(
        .WIDTH(COUNTER_WIDTH)
    ) u_counter16 (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_src(c16_cfg_q[core_io_pkg::C16_SRC_LSB +: 3]),
        .i_div(c16_cfg_q[core_io_pkg::C16_DIV_LSB +: 2]),
        .i_bit_sel(c16_cfg_q[core_io_pkg::C16_SEL_LSB +: 3]),
        .i_fast_tick(fast_tick),
        .i_slow_tick(slow_tick),
        .i_pin4_fall(pin4_fall),
        .i_pin0_fall(pin0_fall),
        .o_count(c16_count),
        .o_event(c16_evt)
    );

    assign o_counter16 = c16_count;
    // ------------------------------------------------------------------
    // Interrupt requests
    // ------------------------------------------------------------------
    // Event vector in request bit positions
    always_comb begin
        evt = 8'h00;
        evt[core_io_pkg::IRQ_AUX_BIT] = i_aux_timer_evt;
        evt[core_io_pkg::IRQ_CMP_BIT] = i_comparator_evt;
        evt[core_io_pkg::IRQ_CNT16_BIT] = c16_evt;
        evt[core_io_pkg::IRQ_PIN0_BIT] = pin0_edge;
    end

    // Software write first, then events OR in so set wins
    always_comb begin
        pend_d = pend_q;
        if (wr_take && idx == core_io_pkg::IDX_IRQ_PENDING) begin
            pend_d = wdat & core_io_pkg::IRQ_IMPL_MASK;
        end
        pend_d = pend_d | evt;
    end

    // Request storage
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_q <= 8'h00;
        end else begin
            pend_q <= pend_d;
        end
    end

    assign o_irq_pending = pend_q;
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_req_start;
        req && !ack_q;
    endsequence
    sequence s_ack_then_drop;
        ack_q ##1 !ack_q;
    endsequence

    chk_bus_ack_timing: assert property (
        s_req_start |=> s_ack_then_drop)
        else $error("ack not given one cycle after request");
    chk_flag_nibble_ones: assert property (
        req && !ack_q && idx == core_io_pkg::IDX_ALU_COND
        |=> rdat_q[7:4] == 4'hF)
        else $error("status upper nibble not ones");
    chk_alu_flag_update: assert property (
        i_alu_upd[3] |=> alu_q[3] == $past(i_alu_flags[3]))
        else $error("overflow flag not updated");
    chk_nibble_carry: assert property (
        i_alu_upd[2] |=> alu_q[2] == $past(i_alu_flags[2]))
        else $error("nibble carry flag not updated");
    chk_carry_update: assert property (
        i_alu_upd[1] |=> alu_q[1] == $past(i_alu_flags[1]))
        else $error("carry flag not updated");
    chk_zero_update: assert property (
        i_alu_upd[0] |=> alu_q[0] == $past(i_alu_flags[0]))
        else $error("zero flag not updated");
    chk_wdt_gated: assert property (
        !clk_sel_q[core_io_pkg::CS_SLOW_BIT] |=> !o_wdt_en)
        else $error("watchdog on with slow oscillator off");
    chk_fast_osc_en: assert property (
        ##1 o_fast_osc_en == ($past(clk_sel_q[core_io_pkg::CS_FAST_BIT])
            && !$past(bg_pd_q)))
        else $error("fast oscillator enable wrong");
    chk_pend_set_wins: assert property (
        evt[core_io_pkg::IRQ_CMP_BIT] |=> pend_q[core_io_pkg::IRQ_CMP_BIT])
        else $error("event lost against clear");
    chk_pend_sticky: assert property (
        pend_q[core_io_pkg::IRQ_AUX_BIT] && !(wr_take
            && idx == core_io_pkg::IDX_IRQ_PENDING)
        |=> pend_q[core_io_pkg::IRQ_AUX_BIT])
        else $error("request cleared without software");
    chk_mask_reserved: assert property (
        (mask_q & ~core_io_pkg::IRQ_IMPL_MASK) == 8'h00)
        else $error("reserved mask bit set");
    chk_reserved_clock: assert property (
        clk_sel_q[core_io_pkg::CS_TYPE_BIT]
        && clk_sel_q[7:5] == 3'h5 |=> o_sysclk_reserved)
        else $error("reserved clock code not flagged");
endmodule

// ===== tb/core_io_control_registers_test.sv
// Self-checking bench for the core I/O register bank
`timescale 1ns/1ps
module core_io_control_registers_test;
    // ---------------------------------------------------------------
    // Stimulus, observed outputs and model state
    // ---------------------------------------------------------------
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_wb_cyc = 1'b0;
    logic i_wb_stb = 1'b0;
    logic i_wb_we = 1'b0;
    logic [7:0] i_wb_adr = 8'h00;
    logic [3:0] i_wb_sel = 4'h0;
    logic [31:0] i_wb_dat = 32'h0;
    logic [3:0] i_alu_upd = 4'h0;
    logic [3:0] i_alu_flags = 4'h0;
    logic i_aux_timer_evt = 1'b0;
    logic i_comparator_evt = 1'b0;
    logic i_port_pin0 = 1'b0;
    logic i_port_pin4 = 1'b0;
    logic i_fast_rc_osc = 1'b0;
    logic [1:0] osc_cnt = 2'h0;
    logic [31:0] o_wb_dat;
    logic o_wb_ack, o_fast_osc_en, o_slow_osc_en, o_wdt_en;
    logic o_ext_reset_sel, o_sysclk_slow, o_sysclk_reserved, o_bandgap_pd;
    logic [3:0] o_alu_flags;
    logic [7:0] o_stack_index, o_irq_mask, o_irq_pending;
    logic [2:0] o_sysclk_div_log2;
    logic [15:0] o_counter16;
    int n_fail = 0;
    int checked = 0;
    int seed;
    logic [3:0] fl = 4'h0;
    logic [7:0] v;
    logic [4:0] e;
    logic [15:0] c0;

    // Clock and a slow free-running fast oscillator level
    always #5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        osc_cnt <= osc_cnt + 2'h1;
        i_fast_rc_osc <= osc_cnt[1];
    end

    core_io_control_registers DUT (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc),
        .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
        .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
        .o_wb_ack(o_wb_ack), .i_alu_upd(i_alu_upd),
        .i_alu_flags(i_alu_flags), .i_aux_timer_evt(i_aux_timer_evt),
        .i_comparator_evt(i_comparator_evt), .i_port_pin0(i_port_pin0),
        .i_port_pin4(i_port_pin4), .i_fast_rc_osc(i_fast_rc_osc),
        .i_slow_rc_osc(1'b0), .o_alu_flags(o_alu_flags),
        .o_stack_index(o_stack_index), .o_fast_osc_en(o_fast_osc_en),
        .o_slow_osc_en(o_slow_osc_en), .o_wdt_en(o_wdt_en),
        .o_ext_reset_sel(o_ext_reset_sel), .o_sysclk_slow(o_sysclk_slow),
        .o_sysclk_div_log2(o_sysclk_div_log2),
        .o_sysclk_reserved(o_sysclk_reserved), .o_irq_mask(o_irq_mask),
        .o_irq_pending(o_irq_pending), .o_bandgap_pd(o_bandgap_pd),
        .o_counter16(o_counter16));

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] got,
                         input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Classic single Wishbone cycle, released only after ack is seen
    task automatic bus(input logic we, input logic [7:0] adr,
                       input logic [7:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_adr <= adr;
        i_wb_sel <= 4'hF;
        i_wb_dat <= {24'h5A5A5A, wd};
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 20);
        if (o_wb_ack !== 1'b1) begin
            n_fail++;
            wrap_up();
        end
        rd = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        i_wb_we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, adr, d, x);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] adr,
                          input logic [7:0] exp);
        logic [31:0] x;
        bus(1'b0, adr, 8'h00, x);
        check(nm, x, {24'h0, exp});
    endtask

    // One-cycle event pulse: 0 comparator, 1 aux timer
    task automatic pulse(input int w);
        @(posedge i_ref_clk);
        if (w == 0) i_comparator_evt <= 1'b1;
        else i_aux_timer_evt <= 1'b1;
        @(posedge i_ref_clk);
        i_comparator_evt <= 1'b0;
        i_aux_timer_evt <= 1'b0;
    endtask

    // Expected {reserved, slow, divide log2} for a clock code
    function automatic logic [4:0] clk_dec(input logic t,
                                           input logic [2:0] c);
        if (!t) begin
            case (c)
                3'h0: return 5'h02;
                3'h1: return 5'h01;
                3'h6: return 5'h0A;
                3'h7: return 5'h08;
                default: return 5'h10;
            endcase
        end
        case (c)
            3'h0: return 5'h04;
            3'h1: return 5'h03;
            3'h2: return 5'h0C;
            3'h3: return 5'h05;
            3'h4: return 5'h06;
            default: return 5'h10;
        endcase
    endfunction

    // Main sequence
    initial begin
        seed = $urandom(32'hF67B);
        repeat (5) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        @(posedge i_ref_clk);
        check("osc_rst", {o_fast_osc_en, o_slow_osc_en, o_wdt_en,
              o_ext_reset_sel, o_sysclk_slow}, 32'h1D);
        rd_chk("clock_rst", 8'h0C, 8'hF6);
        rd_chk("unmapped", 8'h04, 8'h00);
        repeat (6) begin
            @(posedge i_ref_clk);
            v = 8'($urandom);
            i_alu_upd <= v[3:0];
            i_alu_flags <= v[7:4];
            for (int b = 0; b < 4; b++) if (v[b]) fl[b] = v[4+b];
            @(posedge i_ref_clk);
            i_alu_upd <= 4'h0;
            rd_chk("alu_cond", 8'h00, {4'hF, fl});
            check("alu_out", 32'(o_alu_flags), 32'(fl));
        end
        v = 8'($urandom) & 8'hFE;
        wr(8'h08, v);
        rd_chk("stack", 8'h08, v);
        check("stack_out", 32'(o_stack_index), 32'(v));
        for (int t = 0; t < 2; t++) begin
            for (int c = 0; c < 8; c++) begin
                v = {3'(c), 5'($urandom)};
                v[3] = t[0];
                wr(8'h0C, v);
                repeat (2) @(posedge i_ref_clk);
                e = clk_dec(v[3], v[7:5]);
                check("sysclk", 32'({o_sysclk_reserved, e[4] ? 4'h0 :
                      {o_sysclk_slow, o_sysclk_div_log2}}),
                      32'(e));
                check("osc_en", 32'({o_fast_osc_en, o_slow_osc_en, o_wdt_en,
                      o_ext_reset_sel}), 32'({v[4], v[2], v[2] & v[1],
                      v[0]}));
                rd_chk("clock_sel", 8'h0C, v);
            end
        end
        wr(8'h10, 8'hFF);
        rd_chk("mask", 8'h10, 8'h55);
        check("mask_out", 32'(o_irq_mask), 32'h55);
        wr(8'h14, 8'h00);
        pulse(0);
        pulse(1);
        rd_chk("pend_evt", 8'h14, 8'h50);
        fork
            wr(8'h14, 8'h00);
            begin
                repeat (2) @(posedge i_ref_clk);
                i_comparator_evt <= 1'b1;
                @(posedge i_ref_clk);
                i_comparator_evt <= 1'b0;
            end
        join
        rd_chk("pend_race", 8'h14, 8'h10);
        i_port_pin0 <= 1'b1;
        i_port_pin4 <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        rd_chk("pend_pin0", 8'h14, 8'h11);
        wr(8'h14, 8'h00);
        rd_chk("pend_clr", 8'h14, 8'h00);
        wr(8'h18, 8'h08);
        c0 = o_counter16;
        repeat (50) @(posedge i_ref_clk);
        check("cnt_off", 32'(o_counter16), 32'(c0));
        wr(8'h18, 8'h28);
        rd_chk("c16_cfg", 8'h18, 8'h28);
        c0 = o_counter16;
        repeat (256) @(posedge i_ref_clk);
        c0 = o_counter16 - c0;
        check("div4", 32'(c0), 32'h40);
        for (int n = 0; n < 1200 && o_irq_pending[2] !== 1'b1; n++)
            @(posedge i_ref_clk);
        check("c16_evt", 32'(o_irq_pending), 32'h04);
        if (o_irq_pending[2] !== 1'b1) wrap_up();
        // Pin falling-edge sources: pin4 then pin0, both pins toggled together, five falls each
        for (int s = 0; s < 2; s++) begin
            wr(8'h18, s ? 8'hE0 : 8'h60);
            @(posedge i_ref_clk);
            c0 = o_counter16;
            repeat (5) begin
                i_port_pin0 <= 1'b0;
                i_port_pin4 <= 1'b0;
                repeat (4) @(posedge i_ref_clk);
                i_port_pin0 <= 1'b1;
                i_port_pin4 <= 1'b1;
                repeat (4) @(posedge i_ref_clk);
            end
            check("c16_pin", 32'(o_counter16 - c0), 32'h5);
        end
        wr(8'h28, 8'h01);
        repeat (2) @(posedge i_ref_clk);
        check("bg_pd", 32'({o_bandgap_pd, o_fast_osc_en}), 32'h2);
        rd_chk("bg_read", 8'h28, 8'h00);
        wrap_up();
    end
endmodule
